// ### verilog/dac_readback_and_ab_select.sv
`timescale 1ns/1ps
`include "dac_rb_params.svh"
// Contract
// - banks 000-011 return input A, input B, offset trim, gain trim of channel.
// - bank 100 selects control, offset words or select registers 0 to 4.
// - data field bits 6..0 are ignored when decoding the readback address.
// - bit k of select register n steers output channel 8n+k.
// - select bit 0 means register A drives the output, 1 means register B.
// - following no-op frame clocks the selected register out on the serial output.
// - mode bits 00 make a special function: six-bit code, sixteen-bit data.
// - special code 000101 loads the readback address from its data field.
module dac_readback_and_ab_select (
  input  wire logic                 clk,          // system clock, 100 MHz
  input  wire logic                 rst_n,        // async reset, active low
  input  wire logic                 sclk,         // serial clock from host
  input  wire logic                 sync_n,       // frame strobe, active low
  input  wire logic                 sdi,          // serial data in
  output logic                      sdo,          // serial data out
  output logic [`NUM_CH-1:0]        ch_use_b,     // per channel: 1 uses register b
  output dac_rb_pkg::ctrl_type      ctrl,         // control register
  output logic                      frame_done    // pulse per decoded frame
);
  import dac_rb_pkg::*;

  // ---------------- link domain (sclk) ----------------
  logic        frame_idle;
  logic [4:0]  bit_cnt_r;
  logic [22:0] in_sh_r;
  logic [22:0] out_sh_r;
  frame_type   link_word_r;
  logic        link_tgl_r;
  logic        sdo_r;
  logic [23:0] rb_word_r;

  // sclk stops between frames, so the frame strobe itself ends the count
  assign frame_idle = sync_n | ~rst_n;

  always_ff @(posedge sclk or posedge frame_idle) begin
    if (frame_idle) begin
      bit_cnt_r <= `CNT_ZERO;
    end else if (bit_cnt_r != `FRAME_LAST) begin
      bit_cnt_r <= bit_cnt_r + 5'h01;
    end
  end

  // shift in msb first; the full word is handed over on the last bit
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      in_sh_r     <= 23'h000000;
      link_word_r <= '0;
      link_tgl_r  <= 1'b0;
    end else if (!sync_n) begin
      in_sh_r <= {in_sh_r[21:0], sdi};
      if (bit_cnt_r == `FRAME_LAST) begin
        link_word_r <= frame_type'({in_sh_r, sdi}); // held until next frame ends
        link_tgl_r  <= ~link_tgl_r;
      end
    end
  end

  // readback word is loaded on the first edge of every frame
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      out_sh_r <= 23'h000000;
      sdo_r    <= 1'b0;
    end else if (!sync_n) begin
      if (bit_cnt_r == `CNT_ZERO) begin
        sdo_r    <= rb_word_r[23];
        out_sh_r <= rb_word_r[22:0];
      end else begin
        sdo_r    <= out_sh_r[22];
        out_sh_r <= {out_sh_r[21:0], 1'b0};
      end
    end
  end

  assign sdo = sdo_r;

  // ---------------- system domain (clk) ----------------
  logic        tgl_s1_r;
  logic        tgl_s2_r;
  logic        tgl_s3_r;
  logic        new_frame;
  frame_type   fw;
  logic [5:0]  ch_idx;
  logic        ch_ok;

  // toggle handshake; link word is stable long after the toggle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tgl_s1_r <= 1'b0;
      tgl_s2_r <= 1'b0;
      tgl_s3_r <= 1'b0;
    end else begin
      tgl_s1_r <= link_tgl_r;
      tgl_s2_r <= tgl_s1_r;
      tgl_s3_r <= tgl_s2_r;
    end
  end

  assign new_frame = tgl_s2_r ^ tgl_s3_r;
  assign fw        = link_word_r;
  assign ch_idx    = fw.code - `CH_BASE;
  assign ch_ok     = (fw.code >= `CH_BASE) && (fw.code <= `CH_LAST);

  // per-channel data registers
  logic [15:0] reg_a [`NUM_CH];
  logic [15:0] reg_b [`NUM_CH];
  logic [15:0] reg_c [`NUM_CH];
  logic [15:0] reg_m [`NUM_CH];
  logic [15:0] offset_word_0_r;
  logic [15:0] offset_word_1_r;
  logic [7:0]  sel_r [`NUM_SEL];
  ctrl_type    ctrl_r;
  logic [8:0]  rb_addr_r;
  logic        frame_done_r;

  // channel writes; only single-channel addresses are decoded here
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `NUM_CH; i++) begin
        reg_a[i] <= `RST_WORD;
        reg_b[i] <= `RST_WORD;
        reg_c[i] <= `RST_WORD;
        reg_m[i] <= `RST_WORD;
      end
    end else if (new_frame && ch_ok) begin
      case (fw.mode)
        `MODE_INPUT: begin
          if (ctrl_r.input_b) begin
            reg_b[ch_idx] <= fw.data;
          end else begin
            reg_a[ch_idx] <= fw.data;
          end
        end
        `MODE_OFFSET: reg_c[ch_idx] <= fw.data;
        `MODE_GAIN:   reg_m[ch_idx] <= fw.data;
        default: ;
      endcase
    end
  end

  // special functions: six-bit code, sixteen-bit data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      offset_word_0_r <= `RST_WORD;
      offset_word_1_r <= `RST_WORD;
      ctrl_r    <= ctrl_type'(`RST_CTRL);
      rb_addr_r <= `RST_RB_ADDR;
      for (int n = 0; n < `NUM_SEL; n++) begin
        sel_r[n] <= `RST_SEL;
      end
    end else if (new_frame && fw.mode == `MODE_SPECIAL) begin
      case (fw.code)
        `SF_CONTROL:  ctrl_r <= ctrl_type'(fw.data[2:0]);
        `SF_OFFSET_WORD_0: offset_word_0_r <= fw.data & `OFS_MASK;
        `SF_OFFSET_WORD_1: offset_word_1_r <= fw.data & `OFS_MASK;
        `SF_READBACK: rb_addr_r <= fw.data[15:7];   // bits 6..0 dropped
        `SF_SEL_ALL: begin
          for (int n = 0; n < `NUM_SEL; n++) begin
            sel_r[n] <= (fw.data[7:0] == `RST_SEL) ? `RST_SEL : `SEL_ALL_ONES;
          end
        end
        default: begin
          if (fw.code >= `SF_SEL0 && fw.code <= `SF_SEL4) begin
            sel_r[3'(fw.code - `SF_SEL0)] <= fw.data[7:0];
          end
        end
      endcase
    end
  end

  // readback mux, re-evaluated every cycle so the word tracks its source
  logic [2:0]  rb_bank;
  logic [5:0]  rb_sel;
  logic [5:0]  rb_ch;
  logic        rb_ch_ok;
  logic [15:0] rb_val;

  assign rb_bank  = rb_addr_r[8:6];
  assign rb_sel   = rb_addr_r[5:0];
  assign rb_ch    = rb_sel - `CH_BASE;
  assign rb_ch_ok = (rb_sel >= `CH_BASE) && (rb_sel <= `CH_LAST);

  always_comb begin
    rb_val = `RST_WORD;
    case (rb_bank)
      `RB_BANK_A: if (rb_ch_ok) rb_val = reg_a[rb_ch];
      `RB_BANK_B: if (rb_ch_ok) rb_val = reg_b[rb_ch];
      `RB_BANK_C: if (rb_ch_ok) rb_val = reg_c[rb_ch];
      `RB_BANK_M: if (rb_ch_ok) rb_val = reg_m[rb_ch];
      `RB_BANK_GLOBAL: begin
        if (rb_sel == `RB_G_CONTROL) begin
          rb_val = {13'h0000, ctrl_r};
        end else if (rb_sel == `RB_G_OFFSET_WORD_0) begin
          rb_val = offset_word_0_r;
        end else if (rb_sel == `RB_G_OFFSET_WORD_1) begin
          rb_val = offset_word_1_r;
        end else if (rb_sel >= `RB_G_SEL0 && rb_sel <= `RB_G_SEL4) begin
          rb_val = {8'h00, sel_r[3'(rb_sel - `RB_G_SEL0)]};
        end
      end
      default: rb_val = `RST_WORD;
    endcase
  end

  // quasi-static toward the link: host leaves a gap between frames
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rb_word_r <= 24'h000000;
    end else begin
      rb_word_r <= {8'h00, rb_val};
    end
  end

  // output steering: one bit per channel
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ch_use_b     <= {`NUM_CH{1'b0}};
      frame_done_r <= 1'b0;
    end else begin
      for (int n = 0; n < `NUM_SEL; n++) begin
        ch_use_b[8*n +: 8] <= sel_r[n];
      end
      frame_done_r <= new_frame;
    end
  end

  assign ctrl       = ctrl_r;
  assign frame_done = frame_done_r;
endmodule // dac_readback_and_ab_select

// ### verilog/dac_rb_params.svh
`ifndef DAC_RB_PARAMS_SVH
`define DAC_RB_PARAMS_SVH
// frame layout
`define FRAME_BITS      24
`define FRAME_LAST      5'h17
`define CNT_ZERO        5'h00
`define NUM_CH          40
`define CH_BASE         6'h08
`define CH_LAST         6'h2F
`define NUM_SEL         5
// mode field values
`define MODE_SPECIAL    2'h0
`define MODE_GAIN       2'h1
`define MODE_OFFSET     2'h2
`define MODE_INPUT      2'h3
// special function codes
`define SF_NOP          6'h00
`define SF_CONTROL      6'h01
`define SF_OFFSET_WORD_0 6'h02
`define SF_OFFSET_WORD_1 6'h03
`define SF_READBACK     6'h05
`define SF_SEL0         6'h06
`define SF_SEL4         6'h0A
`define SF_SEL_ALL      6'h0B
// readback bank field values (data field bits 15..13)
`define RB_BANK_A       3'h0
`define RB_BANK_B       3'h1
`define RB_BANK_C       3'h2
`define RB_BANK_M       3'h3
`define RB_BANK_GLOBAL  3'h4
// global readback addresses (data field bits 12..7)
`define RB_G_CONTROL    6'h01
`define RB_G_OFFSET_WORD_0 6'h02
`define RB_G_OFFSET_WORD_1 6'h03
`define RB_G_SEL0       6'h06
`define RB_G_SEL4       6'h0A
// reset values, block-select fill value and offset mask
`define RST_WORD        16'h0000
`define RST_SEL         8'h00
`define RST_CTRL        3'h0
`define RST_RB_ADDR     9'h000
`define SEL_ALL_ONES    8'hFF
`define OFS_MASK        16'h3FFF
`endif

// ### verilog/dac_rb_pkg.sv
package dac_rb_pkg;
  // one decoded serial command frame
  typedef struct packed {
    logic [1:0]  mode;  // top two bits
    logic [5:0]  code;  // special code or channel address
    logic [15:0] data;  // data field
  } frame_type;

  // control register bits
  typedef struct packed {
    logic input_b;     // writes go to input register b
    logic therm_en;    // thermal shutdown enabled
    logic power_down;  // soft power-down
  } ctrl_type;
endpackage

// ### sim/dac_rb_properties.sv
`timescale 1ns/1ps
`include "dac_rb_params.svh"
module dac_rb_properties (
  input wire logic                 clk,        // system clock
  input wire logic                 rst_n,      // async reset
  input wire logic                 sclk,       // serial clock
  input wire logic                 sync_n,     // frame strobe
  input wire logic                 sdi,        // serial in
  input wire logic                 sdo,        // serial out
  input wire logic [`NUM_CH-1:0]   ch_use_b,   // per channel select
  input wire dac_rb_pkg::ctrl_type ctrl,       // control bits
  input wire logic                 frame_done  // frame pulse
);
  import dac_rb_pkg::*;
  logic [4:0] bit_cnt_r; // sclk edges seen in this frame
  // cleared the moment a frame ends, so no stale count leaks into the next one
  always_ff @(posedge sclk or posedge sync_n) begin
    if (sync_n) begin
      bit_cnt_r <= 5'h00;
    end else begin
      bit_cnt_r <= bit_cnt_r + 5'h01;
    end
  end
  sequence s_lead; bit_cnt_r >= 5'h01 && bit_cnt_r <= 5'h08; endsequence
  sequence s_in_frame; $past(sync_n, 6) == 1'b0 && $past(sync_n, 7) == 1'b0; endsequence
  property p_lead_zero; @(negedge sclk) disable iff (!rst_n) s_lead |-> !sdo; endproperty
  // steering outputs are copied from the select registers one clock after the pulse
  property p_sel_done;
    @(posedge clk) disable iff (!rst_n) $changed(ch_use_b) |-> $past(frame_done);
  endproperty
  property p_ctrl_done;
    @(posedge clk) disable iff (!rst_n) $changed(ctrl) |-> ##[0:1] frame_done;
  endproperty
  property p_excl; @(posedge clk) disable iff (!rst_n) $changed(ctrl) |-> $stable(ch_use_b); endproperty
  property p_done_gap; @(posedge clk) disable iff (!rst_n) frame_done |=> !frame_done [*8]; endproperty
  property p_done_frame; @(posedge clk) disable iff (!rst_n) frame_done |-> s_in_frame; endproperty
  property p_rst_regs;
    @(posedge clk) disable iff (!rst_n) $rose(rst_n) |-> ch_use_b == '0 && ctrl == 3'h0;
  endproperty
  property p_rst_line; @(posedge clk) disable iff (!rst_n) $rose(rst_n) |-> !sdo && !frame_done; endproperty
  a_lead_zero: assert property (p_lead_zero) else $error("sdo lead bits not zero");
  a_sel_done: assert property (p_sel_done) else $error("select change without frame");
  a_ctrl_done: assert property (p_ctrl_done) else $error("ctrl change without frame");
  a_excl: assert property (p_excl) else $error("ctrl and select changed together");
  a_done_gap: assert property (p_done_gap) else $error("frame_done repeated");
  a_done_frame: assert property (p_done_frame) else $error("frame_done outside frame");
  a_rst_regs: assert property (p_rst_regs) else $error("registers not cleared");
  a_rst_line: assert property (p_rst_line) else $error("lines not cleared");
endmodule // dac_rb_properties
bind dac_readback_and_ab_select dac_rb_properties i_props (
  .clk, .rst_n, .sclk, .sync_n, .sdi, .sdo, .ch_use_b, .ctrl, .frame_done);

// ### sim/dac_rb_host.sv
`timescale 1ns/1ps
module dac_rb_host (
  output logic     sclk,   // serial clock, only in frames
  output logic     sync_n, // frame strobe
  output logic     sdi,    // data to device
  input wire logic sdo     // readback data
);
  int n_frames = 0; // frames sent, for the frame-pulse count
  // short strobe in reset gives every observer a clean frame edge
  initial begin
    sclk = 1'b0;
    sdi = 1'b0;
    sync_n = 1'b0;
    #2 sync_n = 1'b1;
  end
  // one 24-bit frame at 12 ns a bit, msb first both ways
  task automatic xfer(input logic [23:0] w, output logic [23:0] rd);
    #3.3 sync_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sdi = w[i];
      #6 sclk = 1'b1;
      #6 sclk = 1'b0;
      rd[i] = sdo; // taken on the falling edge
    end
    #3 sync_n = 1'b1;
    n_frames++;
    sdi = ~sdi; // released line shows no stale level
    #80; // gap above 60 ns lets the readback word settle
  endtask
endmodule // dac_rb_host

// ### sim/dac_readback_and_ab_select_bench.sv
`timescale 1ns/1ps
`include "dac_rb_params.svh"
module dac_readback_and_ab_select_bench;
  import dac_rb_pkg::*;
  logic               clk = 1'b0;
  logic               rst_n = 1'b0;
  logic               sclk, sync_n, sdi, sdo, frame_done;
  logic [`NUM_CH-1:0] ch_use_b, exp_sel;
  ctrl_type           ctrl;
  logic [23:0]        r;
  int                 n_mismatch = 0, checked = 0, cyc = 0, n_done = 0;
  always #5 clk = ~clk;
  dac_readback_and_ab_select i_dut (
    .clk, .rst_n, .sclk, .sync_n, .sdi, .sdo, .ch_use_b, .ctrl, .frame_done);
  dac_rb_host i_host (.sclk, .sync_n, .sdi, .sdo);
  task check(input string nm, input logic [39:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task stop_test;
    if (n_mismatch == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // write, ask for a register, clock it out with a no-op, compare
  task step(input logic [23:0] w, input logic [8:0] rb, input logic [15:0] e);
    i_host.xfer(w, r);
    i_host.xfer({8'h05, rb, 7'h7F}, r);
    i_host.xfer(24'h000000, r);
    check("readback", {16'h0000, r}, {24'h000000, e});
  endtask
  // frame pulses counted away from the edge that launches them
  always @(negedge clk) begin
    if (frame_done === 1'b1) begin
      n_done++;
    end
  end
  // hang guard, about four times the roughly two thousand cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      n_mismatch++;
      stop_test;
    end
  end
  initial begin
    exp_sel = '0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    check("sel_rst", ch_use_b, exp_sel);
    check("ctrl_rst", {37'h0, ctrl}, 40'h0);
    for (int n = 0; n < 5; n++) begin
      exp_sel[8*n +: 8] = 8'hA1 + 8'(n * 17);
      step({8'h06 + 8'(n), 8'h5A, exp_sel[8*n +: 8]}, {3'h4, 6'h06 + 6'(n)},
           {8'h00, exp_sel[8*n +: 8]});
    end
    check("sel_map", ch_use_b, exp_sel);
    step(24'h010005, 9'h101, 16'h0005);
    check("ctrl", {37'h0, ctrl}, 40'h5);
    step(24'h02FFFF, 9'h102, 16'h3FFF);
    step(24'h03C123, 9'h103, 16'h0123);
    step(24'h04FFFF, 9'h104, 16'h0000);
    step(24'hC8BEEF, 9'h048, 16'hBEEF);
    step(24'h000000, 9'h008, 16'h0000);
    step(24'hAF1357, 9'h0AF, 16'h1357);
    step(24'h6F2468, 9'h0EF, 16'h2468);
    step(24'h010002, 9'h101, 16'h0002);
    check("ctrl_a_path", {37'h0, ctrl}, 40'h2);
    step(24'hC81234, 9'h008, 16'h1234);
    step(24'h000000, 9'h048, 16'hBEEF);
    i_host.xfer(24'h0B0003, r);
    check("blk_one", ch_use_b, {`NUM_CH{1'b1}});
    step(24'h0B0000, 9'h10A, 16'h0000);
    check("blk_zero", ch_use_b, 40'h0);
    check("frames", n_done, i_host.n_frames);
    stop_test;
  end
endmodule // dac_readback_and_ab_select_bench
